// File: verilog/fepc_codec.v
// fast ethernet pcs codec: 4b/5b coding, delimiters, scrambler, serializer,
// link monitor, carrier sense and collision, with an apb register slave.
// assumes the mac drives txd/tx_en/tx_er on pclk, sampled on tx_nibble_en;
// pin inputs (serial data, energy, fiber detect, straps) are asynchronous.
`timescale 1ns/1ps
`include "fepc_map.vh"

module fepc_codec #(
  parameter BIT_DIV = 1,
  parameter SIGDET_ON_CYC = (`FEPC_SIGDET_ON_NS / `FEPC_CLK_PERIOD_NS) + 1,
  parameter SIGDET_OFF_CYC = `FEPC_SIGDET_OFF_NS / `FEPC_CLK_PERIOD_NS
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`FEPC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // mii transmit side
  input wire [3:0] txd,
  input wire tx_en,
  input wire tx_er,
  output wire tx_nibble_en,
  output reg col,
  output reg crs,
  // mii receive side
  output reg [3:0] rxd,
  output reg rx_dv,
  output reg rx_er,
  output reg rx_nibble_en,
  // medium and straps
  output reg tx_serial,
  input wire rx_serial,
  input wire energy_detect,
  input wire fiber_signal_detect_in,
  input wire fiber_mode,
  input wire symbol_bypass_strap,
  input wire [4:0] phy_addr,
  output reg signal_detect,
  output wire link_status
);

  // ----------------------------------------------------------------
  // states and widths
  // ----------------------------------------------------------------
  localparam TX_IDLE = 5'b00001;
  localparam TX_K = 5'b00010;
  localparam TX_DATA = 5'b00100;
  localparam TX_R = 5'b01000;
  localparam TX_HOLD = 5'b10000;
  localparam CNT_W = 24;
  localparam [CNT_W-1:0] ON_CYC = SIGDET_ON_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] OFF_CYC = SIGDET_OFF_CYC[CNT_W-1:0];
  localparam [31:0] DIV_M1 = BIT_DIV - 1;
  localparam [7:0] DIV_LAST = DIV_M1[7:0];

  // ----------------------------------------------------------------
  // code-group tables
  // ----------------------------------------------------------------
  function [4:0] enc4b;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: enc4b = 5'h1E;
        4'h1: enc4b = 5'h09;
        4'h2: enc4b = 5'h14;
        4'h3: enc4b = 5'h15;
        4'h4: enc4b = 5'h0A;
        4'h5: enc4b = 5'h0B;
        4'h6: enc4b = 5'h0E;
        4'h7: enc4b = 5'h0F;
        4'h8: enc4b = 5'h12;
        4'h9: enc4b = 5'h13;
        4'hA: enc4b = 5'h16;
        4'hB: enc4b = 5'h17;
        4'hC: enc4b = 5'h1A;
        4'hD: enc4b = 5'h1B;
        4'hE: enc4b = 5'h1C;
        default: enc4b = 5'h1D;
      endcase
    end
  endfunction

  // returns {valid, nibble}; anything not a data code-group is invalid here
  function [4:0] dec5b;
    input [4:0] cg;
    begin
      case (cg)
        5'h1E: dec5b = 5'h10;
        5'h09: dec5b = 5'h11;
        5'h14: dec5b = 5'h12;
        5'h15: dec5b = 5'h13;
        5'h0A: dec5b = 5'h14;
        5'h0B: dec5b = 5'h15;
        5'h0E: dec5b = 5'h16;
        5'h0F: dec5b = 5'h17;
        5'h12: dec5b = 5'h18;
        5'h13: dec5b = 5'h19;
        5'h16: dec5b = 5'h1A;
        5'h17: dec5b = 5'h1B;
        5'h1A: dec5b = 5'h1C;
        5'h1B: dec5b = 5'h1D;
        5'h1C: dec5b = 5'h1E;
        5'h1D: dec5b = 5'h1F;
        default: dec5b = 5'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // registers over apb
  // ----------------------------------------------------------------
  reg [15:0] basic_ctrl;
  reg [15:0] pcs_ctrl;
  reg err_q;
  wire [4:0] idx = paddr[6:2];
  wire hit_bc = (paddr[`FEPC_ADDR_W-1:7] == 0) && (paddr[1:0] == 2'b00) &&
                (idx == `FEPC_IDX_BASIC_CTRL);
  wire hit_st = (paddr[`FEPC_ADDR_W-1:7] == 0) && (paddr[1:0] == 2'b00) &&
                (idx == `FEPC_IDX_PCS_STATUS);
  wire hit_pc = (paddr[`FEPC_ADDR_W-1:7] == 0) && (paddr[1:0] == 2'b00) &&
                (idx == `FEPC_IDX_PCS_CTRL);
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && !err_q;
  wire [15:0] status_word;

  // zero-wait slave: read data and error are prepared in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= !(hit_bc || hit_st || hit_pc) || (pwrite && hit_st);
      if (hit_bc) begin
        prdata <= {16'h0000, basic_ctrl};
      end else if (hit_st) begin
        prdata <= {16'h0000, status_word};
      end else if (hit_pc) begin
        prdata <= {16'h0000, pcs_ctrl};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // only implemented bits store; the rest read as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_ctrl <= `FEPC_BC_RESET;
      pcs_ctrl <= `FEPC_PC_RESET;
    end else if (wr_acc) begin
      if (hit_bc && pstrb[1]) begin
        basic_ctrl[`FEPC_BC_LOOPBACK] <= pwdata[`FEPC_BC_LOOPBACK];
        basic_ctrl[`FEPC_BC_FULL_DUPLEX] <= pwdata[`FEPC_BC_FULL_DUPLEX];
      end
      if (hit_pc && pstrb[0]) begin
        pcs_ctrl[`FEPC_PC_SYM_BYPASS] <= pwdata[`FEPC_PC_SYM_BYPASS];
        pcs_ctrl[`FEPC_PC_SCR_DISABLE] <= pwdata[`FEPC_PC_SCR_DISABLE];
        pcs_ctrl[`FEPC_PC_REMOTE_LB] <= pwdata[`FEPC_PC_REMOTE_LB];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [5:0] sync1;
  reg [5:0] sync2;
  reg [4:0] addr1;
  reg [4:0] addr2;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      addr1 <= 5'h00;
      addr2 <= 5'h00;
    end else begin
      sync1 <= {rx_serial, energy_detect, fiber_signal_detect_in, fiber_mode,
                symbol_bypass_strap, 1'b0};
      sync2 <= sync1;
      addr1 <= phy_addr;
      addr2 <= addr1;
    end
  end
  wire rx_pin = sync2[5];
  wire energy_s = sync2[4];
  wire fiber_det_s = sync2[3];
  wire fiber_s = sync2[2];
  wire strap_s = sync2[1];

  wire bypass = pcs_ctrl[`FEPC_PC_SYM_BYPASS] || strap_s;
  wire no_scr = fiber_s || pcs_ctrl[`FEPC_PC_SCR_DISABLE];
  wire half_duplex = !basic_ctrl[`FEPC_BC_FULL_DUPLEX];

  // ----------------------------------------------------------------
  // bit and nibble enables
  // ----------------------------------------------------------------
  reg [7:0] div_cnt;
  reg [2:0] bit_cnt;
  reg [1:0] seed_cnt;
  wire seeded = &seed_cnt;
  wire bit_en = seeded && (div_cnt == DIV_LAST);
  wire nib_en = bit_en && (bit_cnt == 3'd4);
  assign tx_nibble_en = nib_en;

  // the bit and nibble enables stay off until the phy address strap has been caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      bit_cnt <= 3'd0;
      seed_cnt <= 2'd0;
    end else begin
      if (!seeded) begin
        seed_cnt <= seed_cnt + 2'd1;
      end
      if (seeded) begin
        div_cnt <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
      end
      if (bit_en) begin
        bit_cnt <= (bit_cnt == 3'd4) ? 3'd0 : bit_cnt + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // signal detect qualifier and link monitor
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] det_cnt;
  reg tp_sig_det;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt <= {CNT_W{1'b0}};
      tp_sig_det <= 1'b0;
    end else if (energy_s == tp_sig_det) begin
      det_cnt <= {CNT_W{1'b0}};
    end else if (det_cnt >= (tp_sig_det ? OFF_CYC : ON_CYC) - 1) begin
      tp_sig_det <= energy_s;
      det_cnt <= {CNT_W{1'b0}};
    end else begin
      det_cnt <= det_cnt + 1'b1;
    end
  end

  // fiber receiver reports energy itself
  wire sig_det_now = fiber_s ? fiber_det_s : tp_sig_det;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_detect <= 1'b0;
    end else begin
      signal_detect <= sig_det_now;
    end
  end

  // link pass follows qualified detect; loopback bits override it
  assign link_status = basic_ctrl[`FEPC_BC_LOOPBACK] ? 1'b0 :
                       pcs_ctrl[`FEPC_PC_REMOTE_LB] ? 1'b1 :
                       signal_detect;
  wire link_fail = !fiber_s && !signal_detect;

  // ----------------------------------------------------------------
  // transmit encoder
  // ----------------------------------------------------------------
  reg [4:0] tx_state;
  reg [4:0] next_state;
  reg [4:0] next_cg;
  reg [4:0] tx_shift;
  reg [10:0] tx_lfsr;
  wire tx_active = (tx_state != TX_IDLE);
  always @* begin
    next_state = tx_state;
    next_cg = `FEPC_CG_IDLE;
    if (bypass) begin
      next_cg = {tx_er, txd};
      next_state = TX_IDLE;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_en && !link_fail) begin
            next_cg = `FEPC_CG_J;
            next_state = TX_K;
          end
        end
        TX_K: begin
          next_cg = `FEPC_CG_K;
          next_state = TX_DATA;
        end
        TX_DATA: begin
          if (!tx_en) begin
            next_cg = `FEPC_CG_T;
            next_state = TX_R;
          end else if (tx_er) begin
            next_cg = `FEPC_CG_H;
          end else begin
            next_cg = enc4b(txd);
          end
        end
        TX_R: begin
          next_cg = `FEPC_CG_R;
          next_state = TX_HOLD;
        end
        TX_HOLD: begin
          next_state = tx_en ? TX_HOLD : TX_IDLE;
        end
        default: begin
          next_state = TX_IDLE;
        end
      endcase
    end
  end

  // the state after r waits for tx_en to drop so one frame never restarts early
  wire tx_key = tx_lfsr[10] ^ tx_lfsr[8];
  wire tx_plain = tx_shift[4];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= `FEPC_CG_IDLE;
      tx_lfsr <= 11'h000;
      tx_serial <= 1'b0;
    end else begin
      if (seed_cnt == 2'd2) begin
        tx_lfsr <= {`FEPC_SEED_HIGH, addr2};
      end else if (bit_en) begin
        tx_lfsr <= {tx_lfsr[9:0], tx_key};
      end
      if (nib_en) begin
        tx_state <= next_state;
        tx_shift <= next_cg;
      end else if (bit_en) begin
        tx_shift <= {tx_shift[3:0], 1'b0};
      end
      if (bit_en) begin
        if (fiber_s) begin
          tx_serial <= tx_serial ^ tx_plain;
        end else if (no_scr) begin
          tx_serial <= tx_plain;
        end else begin
          tx_serial <= tx_plain ^ tx_key;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive descrambler and aligner
  // ----------------------------------------------------------------
  reg rx_prev;
  reg [10:0] rx_lfsr;
  reg [5:0] lock_cnt;
  reg [9:0] rx_win;
  reg [2:0] rx_phase;
  reg in_frame;
  reg wait_r;
  wire desc_lock = lock_cnt[5];
  wire rx_bit = fiber_s ? (rx_pin ^ rx_prev) : rx_pin;
  wire rx_key = rx_lfsr[10] ^ rx_lfsr[8];
  // until locked, assume idles are arriving, so the key is the bit inverted
  wire rx_plain = no_scr ? rx_bit : (rx_bit ^ rx_key);
  wire [9:0] next_win = {rx_win[8:0], rx_plain};
  wire cg_done = in_frame ? (rx_phase == 3'd4) : (bypass && bit_cnt == 3'd4);
  wire jk_seen = (next_win == {`FEPC_CG_J, `FEPC_CG_K});
  wire [4:0] cg = next_win[4:0];
  wire [4:0] dec = dec5b(cg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b0;
      rx_lfsr <= 11'h000;
      lock_cnt <= 6'h00;
      rx_win <= 10'h000;
    end else if (bit_en) begin
      rx_prev <= rx_pin;
      rx_win <= next_win;
      if (!signal_detect || no_scr) begin
        lock_cnt <= 6'h00;
        rx_lfsr <= {rx_lfsr[9:0], ~rx_bit};
      end else if (!desc_lock) begin
        lock_cnt <= (rx_key == ~rx_bit) ? lock_cnt + 6'h01 : 6'h00;
        if (lock_cnt == `FEPC_LOCK_COUNT) begin
          lock_cnt <= 6'h20;
        end
        rx_lfsr <= {rx_lfsr[9:0], ~rx_bit};
      end else begin
        rx_lfsr <= {rx_lfsr[9:0], rx_key};
      end
    end
  end

  // frame and symbol boundary tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_phase <= 3'd0;
      in_frame <= 1'b0;
      wait_r <= 1'b0;
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      rx_nibble_en <= 1'b0;
    end else begin
      rx_nibble_en <= 1'b0;
      if (bit_en) begin
        rx_phase <= (rx_phase == 3'd4) ? 3'd0 : rx_phase + 3'd1;
        if (bypass) begin
          in_frame <= 1'b0;
          wait_r <= 1'b0;
          if (cg_done) begin
            rxd <= cg[3:0];
            rx_er <= cg[4];
            rx_dv <= signal_detect;
            rx_nibble_en <= 1'b1;
          end
        end else if (!in_frame) begin
          if (wait_r && rx_phase == 3'd4) begin
            wait_r <= 1'b0;
            rx_er <= (cg != `FEPC_CG_R);
            rx_nibble_en <= 1'b1;
          end else if (jk_seen && link_status && !wait_r) begin
            in_frame <= 1'b1;
            rx_phase <= 3'd0;
            rxd <= `FEPC_NIB_PREAMBLE;
            rx_dv <= 1'b1;
            rx_er <= 1'b0;
            rx_nibble_en <= 1'b1;
          end else if (rx_phase == 3'd4) begin
            rx_er <= 1'b0;
          end
        end else if (cg_done) begin
          rx_nibble_en <= 1'b1;
          if (cg == `FEPC_CG_T) begin
            in_frame <= 1'b0;
            wait_r <= 1'b1;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
          end else if (cg == `FEPC_CG_IDLE || !signal_detect) begin
            in_frame <= 1'b0;
            rx_dv <= 1'b0;
            rx_er <= 1'b1;
          end else begin
            rxd <= dec[3:0];
            rx_er <= !dec[4];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // carrier sense, collision and status
  // ----------------------------------------------------------------
  wire rx_active = in_frame || wait_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= tx_active || rx_active;
      col <= half_duplex && tx_active && rx_active;
    end
  end

  assign status_word = {11'h000, bypass, fiber_s, link_status, desc_lock, signal_detect};

endmodule

// File: pkg/fepc_map.vh
// constants of the fast ethernet pcs codec: register indices, field positions,
// reset values, code-groups and timing figures.
// assumes it is included by its bare name from the design file.
`ifndef FEPC_MAP_VH
`define FEPC_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FEPC_IDX_BASIC_CTRL 5'h00
`define FEPC_IDX_PCS_STATUS 5'h01
`define FEPC_IDX_PCS_CTRL 5'h15
`define FEPC_ADDR_W 12

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FEPC_BC_LOOPBACK 14
`define FEPC_BC_FULL_DUPLEX 8
`define FEPC_PC_SYM_BYPASS 1
`define FEPC_PC_SCR_DISABLE 2
`define FEPC_PC_REMOTE_LB 3
`define FEPC_ST_SIG_DET 0
`define FEPC_ST_DESC_LOCK 1
`define FEPC_ST_LINK 2
`define FEPC_ST_FIBER 3
`define FEPC_ST_BYPASS 4
`define FEPC_BC_RESET 16'h0000
`define FEPC_PC_RESET 16'h0000

// ----------------------------------------------------------------
// control code-groups
// ----------------------------------------------------------------
`define FEPC_CG_IDLE 5'h1F
`define FEPC_CG_J 5'h18
`define FEPC_CG_K 5'h11
`define FEPC_CG_T 5'h0D
`define FEPC_CG_R 5'h07
`define FEPC_CG_H 5'h04
`define FEPC_NIB_PREAMBLE 4'h5
`define FEPC_SEED_HIGH 6'h01
`define FEPC_LOCK_COUNT 6'h1E

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FEPC_CLK_PERIOD_NS 10
`define FEPC_SIGDET_ON_NS 2000000
`define FEPC_SIGDET_OFF_NS 1000000
`define FEPC_BITS_PER_CG 5

`endif

// File: tb/fepc_monitor.sv
// checker for the pcs codec, watching only the top module's ports.
// assumes BIT_DIV of 1 and pclk as the only clock.
`timescale 1ns/1ps
`include "fepc_map.vh"
module fepc_monitor #(
  parameter SIGDET_ON_CYC = 20,
  parameter SIGDET_OFF_CYC = 10
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`FEPC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  // mii
  input wire tx_en,
  input wire tx_nibble_en,
  input wire col,
  input wire crs,
  input wire rx_nibble_en,
  // medium and link
  input wire energy_detect,
  input wire fiber_mode,
  input wire signal_detect,
  input wire link_status
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  reg [31:0] on_cnt;
  reg [31:0] off_cnt;
  reg lb;
  reg rlb;
  wire acc_wr = psel && penable && pwrite && pready;

  // raw energy run lengths lead the synced copy, so bounds carry slack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt <= 32'h0;
      off_cnt <= 32'h0;
      lb <= 1'b0;
      rlb <= 1'b0;
    end else begin
      on_cnt <= energy_detect ? on_cnt + 32'h1 : 32'h0;
      off_cnt <= energy_detect ? 32'h0 : off_cnt + 32'h1;
      if (acc_wr && paddr == 12'h000 && pstrb[1])
        lb <= pwdata[14];
      if (acc_wr && paddr == 12'h054 && pstrb[0])
        rlb <= pwdata[3];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  nib_period_a: assert property (tx_nibble_en |-> ##5 tx_nibble_en)
    else $error("nibble enable period wrong");
  nib_gap_a: assert property (tx_nibble_en |=> !tx_nibble_en [*4])
    else $error("nibble enable too soon");
  sd_on_a: assert property ($rose(signal_detect) && !fiber_mode
      |-> on_cnt > SIGDET_ON_CYC)
    else $error("signal detect rose early");
  sd_off_late_a: assert property (!fiber_mode && off_cnt > SIGDET_OFF_CYC + 4
      |-> !signal_detect)
    else $error("signal detect held too long");
  sd_off_early_a: assert property (!fiber_mode && $fell(signal_detect)
      |-> off_cnt >= SIGDET_OFF_CYC - 1)
    else $error("signal detect fell early");
  lb_link_low_a: assert property (lb && !rlb |-> !link_status)
    else $error("link high in local loopback");
  rlb_link_high_a: assert property (rlb && !lb |-> link_status)
    else $error("link low in remote loopback");
  col_needs_crs_a: assert property (col |-> crs)
    else $error("collision without carrier");
  rx_pulse_a: assert property (rx_nibble_en |=> !rx_nibble_en)
    else $error("receive nibble enable not a pulse");
  crs_on_tx_a: assert property ($rose(tx_en) && signal_detect |-> ##[1:15] crs)
    else $error("no carrier sense on transmit");

  // main scenarios
  cov_col: cover property (col);
  cov_sd_fall: cover property ($fell(signal_detect));
  cov_err: cover property (pslverr);
endmodule

bind fepc_codec fepc_monitor #(.SIGDET_ON_CYC(SIGDET_ON_CYC), .SIGDET_OFF_CYC(SIGDET_OFF_CYC))
  u_fepc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .tx_en(tx_en), .tx_nibble_en(tx_nibble_en), .col(col), .crs(crs),
  .rx_nibble_en(rx_nibble_en), .energy_detect(energy_detect), .fiber_mode(fiber_mode),
  .signal_detect(signal_detect), .link_status(link_status));

// File: tb/fepc_mac_model.sv
// mac model: sends one fixed frame per start pulse and keeps the last
// received data nibble.
// assumes the codec samples txd on the edge where tx_nibble_en is high.
`timescale 1ns/1ps
module fepc_mac_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // bench control
  input wire start,
  // mii transmit
  input wire tx_nibble_en,
  output reg [3:0] txd,
  output reg tx_en,
  output reg tx_er,
  // mii receive
  input wire [3:0] rxd,
  input wire rx_dv,
  input wire rx_nibble_en,
  output reg [3:0] last_rx
);
  reg busy;
  reg [2:0] idx;

  // preamble pair, then data 0, 1, an errored 3 and F
  function [3:0] frame_nib(input [2:0] i);
    case (i)
      3'h0, 3'h1: frame_nib = 4'h5;
      3'h2: frame_nib = 4'h0;
      3'h3: frame_nib = 4'h1;
      3'h4: frame_nib = 4'h3;
      default: frame_nib = 4'hF;
    endcase
  endfunction

  // next nibble goes out on the taking edge; idle txd keeps changing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      idx <= 3'h0;
      txd <= 4'h0;
      tx_en <= 1'b0;
      tx_er <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      idx <= 3'h0;
      tx_en <= 1'b1;
      txd <= frame_nib(3'h0);
    end else if (busy && tx_nibble_en) begin
      if (idx == 3'h5) begin
        busy <= 1'b0;
        tx_en <= 1'b0;
        tx_er <= 1'b0;
      end else begin
        idx <= idx + 3'h1;
        txd <= frame_nib(idx + 3'h1);
        tx_er <= (idx == 3'h3);
      end
    end else if (!busy) begin
      txd <= ~txd;
    end
  end

  // keep the last nibble delivered inside a frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_rx <= 4'h0;
    else if (rx_nibble_en && rx_dv)
      last_rx <= rxd;
  end
endmodule

// File: tb/fepc_codec_bench.sv
// bench for the pcs codec: apb registers, link monitor, framing on the wire
// assumes the serial output is looped back into the receive pin.
`timescale 1ns/1ps
`include "fepc_map.vh"
module fepc_codec_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg rx_serial = 1'b1;
  reg energy_detect = 1'b0;
  reg fiber_mode = 1'b0, fiber_sd = 1'b0, strap = 1'b0;
  reg mac_start = 1'b0;
  reg [9:0] sh = 10'h000;
  reg crs_seen = 1'b0;
  reg col_seen = 1'b0;
  reg [31:0] rd;
  reg er;
  integer n_fail = 0;
  integer num_checks = 0;
  integer cyc = 0;
  wire pready, pslverr, tx_en, tx_er, tx_nibble_en, col, crs, rx_dv, rx_er;
  wire rx_nibble_en, tx_serial, signal_detect, link_status;
  wire [31:0] prdata;
  wire [3:0] txd, rxd, last_rx;

  fepc_codec #(.BIT_DIV(1), .SIGDET_ON_CYC(20), .SIGDET_OFF_CYC(10)) u_fepc_codec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .tx_nibble_en(tx_nibble_en), .col(col), .crs(crs), .rxd(rxd), .rx_dv(rx_dv),
    .rx_er(rx_er), .rx_nibble_en(rx_nibble_en), .tx_serial(tx_serial),
    .rx_serial(rx_serial), .energy_detect(energy_detect), .fiber_signal_detect_in(fiber_sd),
    .fiber_mode(fiber_mode), .symbol_bypass_strap(strap), .phy_addr(5'h03),
    .signal_detect(signal_detect), .link_status(link_status));
  fepc_mac_model u_fepc_mac_model (.pclk(pclk), .presetn(presetn), .start(mac_start),
    .tx_nibble_en(tx_nibble_en), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .rxd(rxd), .rx_dv(rx_dv), .rx_nibble_en(rx_nibble_en), .last_rx(last_rx));

  // ----------------------------------------
  // clock, loopback wire, watchers, timeout
  // ----------------------------------------
  always #5 pclk = ~pclk;
  // loopback gives receive traffic while transmitting, the collision case
  always @(posedge pclk) begin
    sh <= {sh[8:0], tx_serial};
    rx_serial <= tx_serial;
    crs_seen <= crs_seen | (crs === 1'b1);
    col_seen <= col_seen | (col === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task finish_test;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // one apb transfer; ends at a falling edge so outputs have settled
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
    end
  endtask

  task drive_energy(input v);
    begin
      @(posedge pclk);
      energy_detect <= v;
    end
  endtask

  task wait_sd(input v);
    integer i;
    begin
      i = 0;
      while (signal_detect !== v && i < 60) begin
        @(negedge pclk);
        i = i + 1;
      end
      chk(signal_detect, v);
    end
  endtask

  task pulse_start;
    begin
      @(posedge pclk);
      mac_start <= 1'b1;
      @(posedge pclk);
      mac_start <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      @(posedge pclk);
      strap <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h054, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h080, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, 12'h004, 32'hFFFF);
      chk(er, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[4:0], 5'h10);
      @(posedge pclk);
      strap <= 1'b0;
    end
  endtask

  // no signal: frame refused, line carries scrambled idle
  task t_link_fail;
    integer i, ones;
    begin
      ones = 0;
      pulse_start;
      for (i = 0; i < 60; i = i + 1) begin
        @(negedge pclk);
        ones = ones + (tx_serial === 1'b1);
      end
      chk(ones > 0 && ones < 60, 1'b1);
      chk(crs_seen, 1'b0);
    end
  endtask

  task t_sigdet;
    begin
      drive_energy(1'b1);
      repeat (18) @(negedge pclk);
      chk(signal_detect, 1'b0);
      wait_sd(1'b1);
      chk(link_status, 1'b1);
      drive_energy(1'b0);
      repeat (5) @(negedge pclk);
      chk(signal_detect, 1'b1);
      wait_sd(1'b0);
      drive_energy(1'b1);
      wait_sd(1'b1);
    end
  endtask

  task t_link_force;
    begin
      apb(1'b1, 12'h000, 32'h4000);
      chk(link_status, 1'b0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h054, 32'h8);
      drive_energy(1'b0);
      wait_sd(1'b0);
      chk(link_status, 1'b1);
      apb(1'b1, 12'h054, 32'h0);
      drive_energy(1'b1);
      wait_sd(1'b1);
    end
  endtask

  // unscrambled frame: J K 0 1 H F T R then idle, looped into the receiver
  task t_frame;
    integer i;
    reg [34:0] exp;
    begin
      exp = {5'h1E, 5'h09, 5'h04, 5'h1D, 5'h0D, 5'h07, 5'h1F};
      apb(1'b1, 12'h054, 32'h4);
      pulse_start;
      i = 0;
      while (sh !== 10'h311 && i < 80) begin
        @(negedge pclk);
        i = i + 1;
      end
      chk(sh, 10'h311);
      for (i = 6; i >= 0; i = i - 1) begin
        repeat (5) @(negedge pclk);
        chk(sh[4:0], exp[i*5 +: 5]);
      end
      repeat (40) @(negedge pclk);
      chk(last_rx, 4'hF);
      chk(rx_dv, 1'b0);
      chk(crs_seen, 1'b1);
      chk(col_seen, 1'b1);
      chk(crs, 1'b0);
    end
  endtask

  // fiber: nrzi line, detect from the fiber input
  task t_fiber;
    begin
      @(posedge pclk);
      fiber_sd <= 1'b1;
      fiber_mode <= 1'b1;
      repeat (4) @(negedge pclk);
      chk(tx_serial ^ sh[0], 1'b1);
      @(posedge pclk);
      fiber_sd <= 1'b0;
      wait_sd(1'b0);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_link_fail;
    t_sigdet;
    t_link_force;
    t_frame;
    t_fiber;
    finish_test;
  end
endmodule
